// ===== common/blgc_pkg.sv
// package of constants for the boost low-side gate control block
package blgc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [9:0]  LOWSIDE_EDGE_RATE_SELECT_ADDR = 10'h18F;
  localparam int          REG_WIDTH                     = 16;
  // field positions inside the edge-rate register
  localparam int          RISE_FIELD_LSB                = 0;
  localparam int          FALL_FIELD_LSB                = 2;
  localparam logic [15:0] EDGE_RATE_RESET               = 16'h0000;

  // ****************************************************************
  // edge strength codes
  // ****************************************************************
  localparam logic [1:0]  STRENGTH_1500 = 2'h0;   // fastest
  localparam logic [1:0]  STRENGTH_300  = 2'h1;
  localparam logic [1:0]  STRENGTH_50   = 2'h2;
  localparam logic [1:0]  STRENGTH_25   = 2'h3;   // slowest

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS       = 8;
  localparam int          STRENGTH_SETTLE_NS  = 166;
  // longest time rounds down, at least one cycle
  localparam int          STRENGTH_SETTLE_CYC =
    (STRENGTH_SETTLE_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (STRENGTH_SETTLE_NS / CLK_PERIOD_NS);

  // regulation states
  typedef enum logic [1:0] {
    REG_OFF = 2'b01,
    REG_ON  = 2'b10
  } blgc_reg_state_type;

endpackage : blgc_pkg

// ===== hw/blgc_gate_ctrl.sv
// boost converter low-side gate control with edge-strength register
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - rising and falling gate edge strengths are chosen independently from four settings each.
// - both selects come from writable fields of the edge-rate register at 0x18F.
// - rising select 00 is 1500 V/us, 01 is 300, 10 is 50 and 11 is 25.
// - falling select uses the same code order, 00 fastest to 11 slowest.
// - a newly written strength reaches the driver within one clock cycle.
// - the gate is forced low at once during reset, and at the next enabled clock edge while not operating.
// - inductor current is regulated by hard-wired two-point logic driving the gate.
// - the converter sense channel also flags capacitor overcurrent during regulation.
// - a third comparator on the sense channel flags negative current.
// - gate is high only with request or regulation on, enable or override, no undervoltage and clock valid.
module blgc_gate_ctrl
  import blgc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        clk_en_i,
  // register port
  input  wire logic [9:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // drive qualification
  input  wire logic        gate_request_i,
  input  wire logic        regulation_en_i,
  input  wire logic        drive_enable_i,
  input  wire logic        gate_enable_override_i,
  input  wire logic        predrive_supply_low_i,
  input  wire logic        logic_supply_low_i,
  input  wire logic        clock_valid_i,
  // current sense comparators
  input  wire logic        coil_current_high_feedback_i,
  input  wire logic        coil_current_low_feedback_i,
  input  wire logic        negative_current_feedback_i,
  input  wire logic        overcurrent_feedback_i,
  // driver side
  output logic             boost_gate_out_o,
  output logic [1:0]       rise_strength_select_o,
  output logic [1:0]       fall_strength_select_o,
  output logic             negative_current_flag_o,
  output logic             overcurrent_flag_o
);

  // ****************************************************************
  // feedback synchronisation
  // ****************************************************************
  logic [3:0] fbk_sync;

  blgc_sync2 #(
    .WIDTH (4)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .clk_en_i  (clk_en_i),
    .async_i   ({overcurrent_feedback_i, negative_current_feedback_i,
                 coil_current_low_feedback_i,
                 coil_current_high_feedback_i}),
    .sync_o    (fbk_sync)
  );

  // bit order on the synchroniser: 0 high, 1 low, 2 negative, 3 overcurrent
  // the two sync flops add two cycles of loop latency, the price paid
  // for taking raw comparator edges safely into the clock domain
  logic fbk_high;
  logic fbk_low;
  assign fbk_high = fbk_sync[0];
  assign fbk_low  = fbk_sync[1];

  // ****************************************************************
  // edge-rate register
  // ****************************************************************
  logic [REG_WIDTH-1:0] edge_rate_q;
  logic [REG_WIDTH-1:0] edge_rate_d;
  logic [15:0]          rdata_q;
  logic [15:0]          rdata_d;
  logic [1:0]           rise_sel_q;
  logic [1:0]           rise_sel_d;
  logic [1:0]           fall_sel_q;
  logic [1:0]           fall_sel_d;
  logic                 hit;

  // only one address is decoded; every other address reads back zero
  // and swallows writes, so a stray access cannot retune the driver
  assign hit = (reg_addr_i == LOWSIDE_EDGE_RATE_SELECT_ADDR);

  // register write, read-back and select decode
  always_comb begin
    edge_rate_d = edge_rate_q;
    rdata_d     = rdata_q;
    if (clk_en_i && reg_wr_i && hit) begin
      // bits outside the two strength fields are dropped, not stored
      edge_rate_d = 16'h0000;
      edge_rate_d[RISE_FIELD_LSB +: 2] = reg_wdata_i[RISE_FIELD_LSB +: 2];
      edge_rate_d[FALL_FIELD_LSB +: 2] = reg_wdata_i[FALL_FIELD_LSB +: 2];
    end
    // unmapped reads return zero
    // a read in the same cycle as a write returns the old contents
    if (clk_en_i && reg_rd_i) begin
      rdata_d = hit ? edge_rate_q : 16'h0000;
    end
    // the selects are registered copies so the driver sees a flop output
    // independent rise and fall selects
    // rise code passed straight to pmos strength
    // fall code passed straight to nmos strength
    // the new value lands on the driver one cycle after the write
    rise_sel_d = clk_en_i ? edge_rate_d[RISE_FIELD_LSB +: 2] : rise_sel_q;
    fall_sel_d = clk_en_i ? edge_rate_d[FALL_FIELD_LSB +: 2] : fall_sel_q;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edge_rate_q <= EDGE_RATE_RESET;
      rdata_q     <= 16'h0000;
      rise_sel_q  <= STRENGTH_1500;
      fall_sel_q  <= STRENGTH_1500;
    end else begin
      edge_rate_q <= edge_rate_d;
      rdata_q     <= rdata_d;
      rise_sel_q  <= rise_sel_d;
      fall_sel_q  <= fall_sel_d;
    end
  end

  // ****************************************************************
  // two-point regulation and gate qualification
  // ****************************************************************
  blgc_reg_state_type state_q;
  blgc_reg_state_type state_d;
  logic               gate_q;
  logic               gate_d;
  logic               allow;
  logic               neg_q;
  logic               neg_d;
  logic               ovc_q;
  logic               ovc_d;

  // override stands in for the global enable, never for the supplies
  // enable, supplies and clock valid must all agree
  assign allow = (drive_enable_i || gate_enable_override_i) &&
                 !predrive_supply_low_i && !logic_supply_low_i &&
                 clock_valid_i;

  // regulation state and gate value
  // hysteresis comes from the two comparator thresholds, not a counter;
  // the state stays OFF until both comparators are clear, so a noisy
  // low comparator alone cannot restart the switch early
  always_comb begin
    state_d = state_q;
    gate_d  = gate_q;
    neg_d   = neg_q;
    ovc_d   = ovc_q;
    // a low clock enable freezes state, gate and flags together
    if (clk_en_i) begin
      // hard-wired hysteretic loop, no microcore in path
      // off at high threshold, on again when low releases
      unique case (state_q)
        REG_ON: begin
          if (fbk_high) begin
            state_d = REG_OFF;
          end
        end
        REG_OFF: begin
          if (!fbk_low && !fbk_high) begin
            state_d = REG_ON;
          end
        end
        default: state_d = REG_OFF;
      endcase
      // any disqualifier drops the loop to OFF, so it restarts cleanly
      if (!allow || !regulation_en_i) begin
        state_d = REG_OFF;
      end
      // gate follows request when not regulating
      if (regulation_en_i) begin
        gate_d = allow && (state_d == REG_ON);
      end else begin
        gate_d = allow && gate_request_i;
      end
      neg_d = fbk_sync[2];
      ovc_d = fbk_sync[3];
    end
  end

  // async clear drops the gate even while the clock is stopped
  // reset forces the gate low at once
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= REG_OFF;
      gate_q  <= 1'b0;
      neg_q   <= 1'b0;
      ovc_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      gate_q  <= gate_d;
      neg_q   <= neg_d;
      ovc_q   <= ovc_d;
    end
  end

  // every output is the plain output of a flop, so no glitch from the
  // qualification logic can reach the external switch
  assign boost_gate_out_o        = gate_q;
  assign rise_strength_select_o  = rise_sel_q;
  assign fall_strength_select_o  = fall_sel_q;
  assign negative_current_flag_o = neg_q;
  assign overcurrent_flag_o      = ovc_q;
  assign reg_rdata_o             = rdata_q;

endmodule : blgc_gate_ctrl
`default_nettype wire

// ===== hw/blgc_sync2.sv
// two-flop synchroniser for comparator feedbacks
`timescale 1ns/100ps
`default_nettype none

module blgc_sync2 #(
  parameter int WIDTH = 3
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // next values: first stage feeds only the second
  always_comb begin
    meta_d = clk_en_i ? async_i : meta_q;
    sync_d = clk_en_i ? meta_q  : sync_q;
  end

  // registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : blgc_sync2
`default_nettype wire

// ===== verification/blgc_coil_model.sv
// behavioural inductor and current comparators beyond the gate
`timescale 1ns/100ps
`default_nettype none
module blgc_coil_model #(
  parameter int HI = 20,
  parameter int LO = 10
) (
  input  wire logic sys_clk_i,
  input  wire logic gate_i,
  output logic      high_fb_o,
  output logic      low_fb_o,
  output int        level_o
);
  int cur_q = 0;
  // current ramps while the switch conducts, decays to zero otherwise
  always @(posedge sys_clk_i) begin
    if (gate_i) cur_q <= cur_q + 1;
    else if (cur_q > 0) cur_q <= cur_q - 1;
  end
  // the HI and LO thresholds set the ripple, widened by the loop latency
  assign high_fb_o = cur_q >= HI;
  assign low_fb_o = cur_q > LO;
  assign level_o = cur_q;
endmodule : blgc_coil_model
`default_nettype wire

// ===== verification/blgc_gate_chk.sv
// port checker for the boost gate control block
`timescale 1ns/100ps
`default_nettype none
module blgc_gate_chk
  import blgc_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        clk_en_i,
  input wire logic [9:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        drive_enable_i,
  input wire logic        gate_enable_override_i,
  input wire logic        predrive_supply_low_i,
  input wire logic        logic_supply_low_i,
  input wire logic        clock_valid_i,
  input wire logic        regulation_en_i,
  input wire logic        coil_current_high_feedback_i,
  input wire logic        negative_current_feedback_i,
  input wire logic        overcurrent_feedback_i,
  input wire logic        boost_gate_out_o,
  input wire logic [1:0]  rise_strength_select_o,
  input wire logic [1:0]  fall_strength_select_o,
  input wire logic        negative_current_flag_o,
  input wire logic        overcurrent_flag_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // decode and qualification; a low clock enable freezes the block
  wire sel = reg_addr_i == LOWSIDE_EDGE_RATE_SELECT_ADDR;
  wire ok = (drive_enable_i || gate_enable_override_i) && clock_valid_i
    && !predrive_supply_low_i && !logic_supply_low_i;
  AST_WR_RISE: assert property (
    clk_en_i && sel && reg_wr_i |=>
      rise_strength_select_o == $past(reg_wdata_i[1:0]))
    else $error("rise select not written");
  AST_WR_FALL: assert property (
    clk_en_i && sel && reg_wr_i |=>
      fall_strength_select_o == $past(reg_wdata_i[3:2]))
    else $error("fall select not written");
  AST_RD_VAL: assert property (
    clk_en_i && sel && reg_rd_i |=> reg_rdata_o == {12'h000,
      $past(fall_strength_select_o), $past(rise_strength_select_o)})
    else $error("edge rate readback wrong");
  AST_RST_LOW: assert property (disable iff (1'h0)
    !rstn_i |-> !boost_gate_out_o && rise_strength_select_o == 2'h0
      && fall_strength_select_o == 2'h0)
    else $error("gate or select not cleared in reset");
  AST_QUAL_ON: assert property (
    $rose(boost_gate_out_o) |-> $past(ok))
    else $error("gate rose unqualified");
  AST_QUAL_OFF: assert property (
    clk_en_i && !ok |=> !boost_gate_out_o)
    else $error("gate high while disqualified");
  AST_HIGH_OFF: assert property (
    (clk_en_i && regulation_en_i && coil_current_high_feedback_i) [*3]
      |=> !boost_gate_out_o)
    else $error("gate on above high threshold");
  AST_NEG_FLAG: assert property (
    (clk_en_i && negative_current_feedback_i) [*3] |=>
      negative_current_flag_o)
    else $error("negative current not flagged");
  AST_OVC_FLAG: assert property (
    (clk_en_i && overcurrent_feedback_i) [*3] |=> overcurrent_flag_o)
    else $error("overcurrent not flagged");
  cover property (regulation_en_i && $fell(boost_gate_out_o));
  cover property (sel && reg_wr_i);
  cover property ($rose(negative_current_flag_o));
endmodule : blgc_gate_chk
bind blgc_gate_ctrl blgc_gate_chk u_chk (.*);
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the boost gate control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import blgc_pkg::*;
  localparam logic [9:0] A = LOWSIDE_EDGE_RATE_SELECT_ADDR;
  logic sys_clk_i = 1'h0, rstn_i = 1'h1, clk_en_i = 1'h1, reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0, gate_request_i = 1'h0, regulation_en_i = 1'h0;
  logic drive_enable_i = 1'h0, gate_enable_override_i = 1'h0;
  logic predrive_supply_low_i = 1'h0, logic_supply_low_i = 1'h0;
  logic clock_valid_i = 1'h0, negative_current_feedback_i = 1'h0;
  logic overcurrent_feedback_i = 1'h0, prev, coil_current_high_feedback_i;
  logic coil_current_low_feedback_i, boost_gate_out_o;
  logic negative_current_flag_o, overcurrent_flag_o;
  logic [9:0] reg_addr_i = 10'h000;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
  logic [1:0] rise_strength_select_o, fall_strength_select_o;
  // enable, override, two supply faults, clock valid, expected gate
  logic [5:0] pat [6] = '{6'h23, 6'h13, 6'h02, 6'h2A, 6'h26, 6'h20};
  int level, peak, rises, mismatches = 0, cmp_count = 0, cyc = 0;
  blgc_gate_ctrl uut (.*);
  blgc_coil_model coil (.sys_clk_i, .gate_i(boost_gate_out_o),
    .high_fb_o(coil_current_high_feedback_i), .level_o(level),
    .low_fb_o(coil_current_low_feedback_i));
  // free running clock
  initial forever #4 sys_clk_i = ~sys_clk_i;
  // hang guard, the run needs under a thousand cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // one register cycle; a read compares its data against d
  task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h0;
    reg_rd_i <= 1'h0;
    #1;
    if (!w) cmp(reg_rdata_o, d);
  endtask : bus
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : hold
  task automatic conclude;
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    // a real falling edge so the asynchronous clear fires at time zero
    rstn_i <= 1'h0;
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    bus(1'h0, A, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, A, {12'hFFF, 2'(3 - i), 2'(i)});
      cmp({12'h000, fall_strength_select_o, rise_strength_select_o},
        {12'h000, 2'(3 - i), 2'(i)});
      bus(1'h0, A, {12'h000, 2'(3 - i), 2'(i)});
    end
    bus(1'h1, 10'h18E, 16'h000F);
    bus(1'h0, A, 16'h0003);
    bus(1'h0, 10'h18E, 16'h0000);
    // a write while the clock enable is low must not land
    @(posedge sys_clk_i);
    clk_en_i <= 1'h0;
    bus(1'h1, A, 16'h000C);
    cmp({12'h000, fall_strength_select_o, rise_strength_select_o},
      16'h0003);
    @(posedge sys_clk_i);
    clk_en_i <= 1'h1;
    bus(1'h0, A, 16'h0003);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk_i);
      gate_request_i <= 1'h1;
      {drive_enable_i, gate_enable_override_i, predrive_supply_low_i,
        logic_supply_low_i, clock_valid_i} <= pat[i][5:1];
      hold(3);
      cmp({15'h0000, boost_gate_out_o}, {15'h0000, pat[i][0]});
    end
    // request low keeps the gate off even when fully qualified
    @(posedge sys_clk_i);
    {drive_enable_i, clock_valid_i, gate_request_i} <= 3'h6;
    hold(3);
    cmp({15'h0000, boost_gate_out_o}, 16'h0000);
    @(posedge sys_clk_i);
    gate_request_i <= 1'h1;
    hold(3);
    cmp({15'h0000, boost_gate_out_o}, 16'h0001);
    // reset with the gate on must drop it without a clock edge
    @(posedge sys_clk_i);
    {drive_enable_i, clock_valid_i} <= 2'h3;
    rstn_i <= 1'h0;
    #1;
    cmp({11'h000, boost_gate_out_o, fall_strength_select_o,
      rise_strength_select_o}, 16'h0000);
    @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    regulation_en_i <= 1'h1;
    hold(50);
    peak = 0;
    rises = 0;
    prev = boost_gate_out_o;
    repeat (150) begin
      hold(1);
      if (level > peak) peak = level;
      if (boost_gate_out_o && !prev) rises++;
      prev = boost_gate_out_o;
    end
    cmp(16'(peak >= 20 && peak <= 24 && rises >= 3), 16'h0001);
    @(posedge sys_clk_i);
    negative_current_feedback_i <= 1'h1;
    overcurrent_feedback_i <= 1'h1;
    hold(4);
    cmp({14'h0000, negative_current_flag_o, overcurrent_flag_o},
      16'h0003);
    // flags are plain levels and must fall with their comparators
    @(posedge sys_clk_i);
    negative_current_feedback_i <= 1'h0;
    overcurrent_feedback_i <= 1'h0;
    hold(4);
    cmp({14'h0000, negative_current_flag_o, overcurrent_flag_o},
      16'h0000);
    conclude();
  end
endmodule : tb
`default_nettype wire
